// ---- pkg/oscs_pkg.sv ----
// Constants for the oscillator select and tuning block.
// Assumes a 200 MHz bus clock and a 32-bit AHB-Lite register slave.
`default_nettype none

package oscs_pkg;

   // ----------------------------------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_TUNE = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_SEC = 8'h08;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int TUNE_LFSS_BIT = 7;
   localparam int TUNE_MULT_BIT = 6;
   localparam int TUNE_VAL_LSB = 0;
   localparam int CTRL_IDLE_BIT = 7;
   localparam int CTRL_IFS_LSB = 4;
   localparam int CTRL_OSTAT_BIT = 3;
   localparam int CTRL_INTERNAL_STABLE_STATUS_BIT = 2;
   localparam int CTRL_SCS_LSB = 0;
   localparam int SEC_RUN_BIT = 6;
   localparam int SEC_EN_BIT = 3;

   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam logic [2:0] IFS_RESET = 3'h4;
   localparam logic [2:0] IFS_8MHZ = 3'h7;
   localparam logic [2:0] IFS_4MHZ = 3'h6;
   localparam logic [2:0] IFS_31KHZ = 3'h0;
   localparam logic [1:0] SRC_PRI = 2'h0;
   localparam logic [1:0] SRC_SEC = 2'h1;
   localparam logic [1:0] SRC_INT = 2'h2;
   localparam logic [3:0] PCFG_INT_A = 4'h9;
   localparam logic [3:0] PCFG_INT_B = 4'h8;
   localparam logic [8:0] DIV_LF_FAST = 9'h100;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int TUNE_SETTLE_US = 1000;
   localparam int TUNE_SETTLE_CYC = TUNE_SETTLE_US * CLK_MHZ;
   localparam logic [2:0] OLD_SRC_CYC = 3'h2;
   localparam logic [2:0] NEW_SRC_CYC = 3'h3;

   typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} oscs_sw_t;
   typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_SLEEP} oscs_pwr_t;

endpackage : oscs_pkg

`default_nettype wire

// ---- hdl/oscs_top.sv ----
// Clock source select, internal oscillator frequency and tuning control.
// Assumes source edge ticks come from logic on hclk; ready pins are async.
//
// Function
// - Low-frequency select set gives fast oscillator divided by 256.
// - Multiplier enable works at 4/8 MHz only; reads zero when absent.
// - Five-bit tuning field is a signed offset around calibration.
// - Clock select 1x internal, 01 secondary, 00 primary.
// - Writing clock select switches source at once after transition.
// - Clock select clears to zero on every reset.
// - Frequency select codes map 8 MHz down to 31 kHz.
// - Frequency select change acts at once while internal block runs.
// - Low-frequency select matters only for frequency code 000.
// - Watchdog and clock monitor always run from slow RC.
// - Start-up status reads one once primary oscillator ready.
// - Internal-stable status reads one when fast oscillator stable and used.
// - Secondary-running status shows secondary oscillator clocks device.
// - At most one clock-source status bit set at a time.
// - Idle enable picks idle, else full sleep, on sleep request.
// - Secondary selection ignored unless secondary oscillator enabled.
// - Switch pauses clock two old plus three-four new cycles.
// - Frequency select resets to 100, giving 1 MHz.
// - Start-up status behaviour depends on two-speed start-up setting.
// - Multiplier runs only with internal primary config and 4/8 MHz.
// - Tuning write settles within 1 ms, no status flag.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`default_nettype none

module oscs_top #(
   parameter int SETTLE_CYCLES = oscs_pkg::TUNE_SETTLE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [3:0] primary_oscillator_config,
   input wire logic two_speed_startup_config,
   input wire logic primary_ready_pin,
   input wire logic fast_stable_pin,
   input wire logic [2:0] src_tick,
   input wire logic sleep_req,
   input wire logic wake_req,
   output logic [1:0] active_src,
   output logic clock_hold,
   output logic [8:0] post_div,
   output logic lf_from_fast,
   output logic mult_active,
   output logic [4:0] tune_offset,
   output logic tune_settling,
   output logic idle_mode,
   output logic sleep_mode,
   output logic wdt_from_slow_rc
);

   localparam int SW = $clog2(SETTLE_CYCLES + 1);

   typedef struct packed {
      logic wr_ph;
      logic [7:0] addr_ph;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic lfss;
      logic mult;
      logic [4:0] tune;
      logic idle_en;
      logic [2:0] ifs;
      logic [1:0] scs;
      logic sec_en;
      logic [1:0] act;
      logic [1:0] tgt;
      oscs_pkg::oscs_sw_t sw;
      logic [2:0] tick_cnt;
      logic hold;
      logic [2:0] sync_p;
      logic [2:0] sync_f;
      logic prim_rdy;
      logic fast_rdy;
      oscs_pkg::oscs_pwr_t pwr;
      logic [SW-1:0] settle_cnt;
      logic settling;
      logic mult_act;
      logic [8:0] post_div;
      logic lf_fast;
      logic wdt_slow;
      logic idle_q;
      logic sleep_q;
   } oscs_state_t;

   oscs_state_t s_ff;
   oscs_state_t nxt_s;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Postscaler divide ratio from the 8 MHz source
   function automatic logic [8:0] oscs_div_ratio(input logic [2:0] ifs,
                                                 input logic lfss);
      logic [8:0] r;
      r = 9'h000;
      if (ifs == oscs_pkg::IFS_31KHZ) begin
         r = lfss ? oscs_pkg::DIV_LF_FAST : 9'h000;
      end else begin
         r = 9'h001 << (3'h7 - ifs);
      end
      return r;
   endfunction : oscs_div_ratio

   function automatic logic [1:0] oscs_src_of(input logic [1:0] scs);
      return scs[1] ? oscs_pkg::SRC_INT : scs;
   endfunction : oscs_src_of

   logic mult_avail;
   logic ostat_now;
   logic internal_stable_status_now;
   logic secrun_now;
   logic [1:0] want_src;
   logic addr_go;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      mult_avail = (primary_oscillator_config == oscs_pkg::PCFG_INT_A) ||
                   (primary_oscillator_config == oscs_pkg::PCFG_INT_B);
      addr_go = hsel && htrans[1] && hready;

      // Ready pins: three stages, accept once stages two and three agree
      nxt_s.sync_p = {s_ff.sync_p[1:0], primary_ready_pin};
      nxt_s.sync_f = {s_ff.sync_f[1:0], fast_stable_pin};
      if (s_ff.sync_p[1] == s_ff.sync_p[2]) begin
         nxt_s.prim_rdy = s_ff.sync_p[2];
      end
      if (s_ff.sync_f[1] == s_ff.sync_f[2]) begin
         nxt_s.fast_rdy = s_ff.sync_f[2];
      end

      // Register writes in the data phase
      if (s_ff.wr_ph) begin
         case (s_ff.addr_ph)
            oscs_pkg::OFS_TUNE: begin
               nxt_s.lfss = hwdata[oscs_pkg::TUNE_LFSS_BIT];
               nxt_s.mult = hwdata[oscs_pkg::TUNE_MULT_BIT] &&
                            mult_avail;
               nxt_s.tune = hwdata[oscs_pkg::TUNE_VAL_LSB +: 5];
               nxt_s.settle_cnt = SW'(SETTLE_CYCLES);
               nxt_s.settling = 1'b1;
            end
            oscs_pkg::OFS_CTRL: begin
               // Status bits 3:2 are not stored: writes fall away
               nxt_s.idle_en = hwdata[oscs_pkg::CTRL_IDLE_BIT];
               nxt_s.ifs = hwdata[oscs_pkg::CTRL_IFS_LSB +: 3];
               nxt_s.scs = hwdata[oscs_pkg::CTRL_SCS_LSB +: 2];
            end
            oscs_pkg::OFS_SEC: begin
               nxt_s.sec_en = hwdata[oscs_pkg::SEC_EN_BIT];
            end
            default: begin
            end
         endcase
      end
      if (!mult_avail) begin
         nxt_s.mult = 1'b0;
      end

      // Tuning settle timer, no flag in any register
      if (!(s_ff.wr_ph && s_ff.addr_ph == oscs_pkg::OFS_TUNE)) begin
         if (s_ff.settle_cnt != '0) begin
            nxt_s.settle_cnt = s_ff.settle_cnt - SW'(1);
         end
         nxt_s.settling = (s_ff.settle_cnt > SW'(1));
      end

      // Power state on sleep request
      case (s_ff.pwr)
         oscs_pkg::PWR_RUN: begin
            if (sleep_req) begin
               nxt_s.pwr = s_ff.idle_en ? oscs_pkg::PWR_IDLE
                                        : oscs_pkg::PWR_SLEEP;
            end
         end
         oscs_pkg::PWR_IDLE, oscs_pkg::PWR_SLEEP: begin
            if (wake_req) begin
               nxt_s.pwr = oscs_pkg::PWR_RUN;
            end
         end
         default: nxt_s.pwr = oscs_pkg::PWR_RUN;
      endcase
      nxt_s.idle_q = (nxt_s.pwr == oscs_pkg::PWR_IDLE);
      nxt_s.sleep_q = (nxt_s.pwr == oscs_pkg::PWR_SLEEP);

      // Glitch-free switch: pause over old then new source edges
      want_src = oscs_src_of(nxt_s.scs);
      case (s_ff.sw)
         oscs_pkg::SW_IDLE: begin
            // A switch to secondary only starts while its oscillator is enabled
            if (want_src != s_ff.act && s_ff.pwr != oscs_pkg::PWR_SLEEP &&
                !(want_src == oscs_pkg::SRC_SEC && !s_ff.sec_en)) begin
               nxt_s.sw = oscs_pkg::SW_OLD;
               nxt_s.tgt = want_src;
               nxt_s.hold = 1'b1;
               nxt_s.tick_cnt = 3'h0;
            end
         end
         oscs_pkg::SW_OLD: begin
            if (src_tick[s_ff.act]) begin
               nxt_s.tick_cnt = s_ff.tick_cnt + 3'h1;
               if (s_ff.tick_cnt + 3'h1 == oscs_pkg::OLD_SRC_CYC) begin
                  nxt_s.sw = oscs_pkg::SW_NEW;
                  nxt_s.tick_cnt = 3'h0;
               end
            end
         end
         oscs_pkg::SW_NEW: begin
            // Third edge of the new source ends the pause and makes it active
            if (src_tick[s_ff.tgt]) begin
               nxt_s.tick_cnt = s_ff.tick_cnt + 3'h1;
               if (s_ff.tick_cnt + 3'h1 == oscs_pkg::NEW_SRC_CYC) begin
                  nxt_s.sw = oscs_pkg::SW_IDLE;
                  nxt_s.act = s_ff.tgt;
                  nxt_s.hold = 1'b0;
               end
            end
         end
         default: begin
            nxt_s.sw = oscs_pkg::SW_IDLE;
            nxt_s.hold = 1'b0;
         end
      endcase

      // Derived clock controls change in the same cycle as the field
      nxt_s.post_div = oscs_div_ratio(nxt_s.ifs, nxt_s.lfss);
      nxt_s.lf_fast = (nxt_s.ifs == oscs_pkg::IFS_31KHZ) &&
                      nxt_s.lfss;
      nxt_s.mult_act = nxt_s.mult && mult_avail &&
                       (nxt_s.ifs == oscs_pkg::IFS_8MHZ ||
                        nxt_s.ifs == oscs_pkg::IFS_4MHZ);
      nxt_s.wdt_slow = 1'b1;

      // Status: only the source now in use may report, so at most one
      ostat_now = (s_ff.act == oscs_pkg::SRC_PRI) && !s_ff.hold &&
                  (s_ff.prim_rdy || !two_speed_startup_config);
      internal_stable_status_now = (s_ff.act == oscs_pkg::SRC_INT) && !s_ff.hold &&
                 s_ff.fast_rdy && !(s_ff.ifs == oscs_pkg::IFS_31KHZ &&
                 !s_ff.lfss);
      secrun_now = (s_ff.act == oscs_pkg::SRC_SEC) && !s_ff.hold;

      // Bus address phase; reads see any write completing now
      nxt_s.hreadyout = 1'b1;
      nxt_s.hresp = 1'b0;
      nxt_s.wr_ph = addr_go && hwrite;
      nxt_s.addr_ph = addr_go ? haddr[7:0] : 8'h00;
      if (addr_go && !hwrite) begin
         case (haddr[7:0])
            oscs_pkg::OFS_TUNE:
               nxt_s.hrdata = {24'h000000, nxt_s.lfss, nxt_s.mult, 1'b0,
                               nxt_s.tune};
            oscs_pkg::OFS_CTRL:
               nxt_s.hrdata = {24'h000000, nxt_s.idle_en, nxt_s.ifs,
                               ostat_now, internal_stable_status_now, nxt_s.scs};
            oscs_pkg::OFS_SEC:
               nxt_s.hrdata = {25'h0000000, secrun_now, 2'h0,
                               nxt_s.sec_en, 3'h0};
            default: nxt_s.hrdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= '0;
         s_ff.hreadyout <= 1'b1;
         s_ff.ifs <= oscs_pkg::IFS_RESET;
         s_ff.sw <= oscs_pkg::SW_IDLE;
         s_ff.pwr <= oscs_pkg::PWR_RUN;
         s_ff.post_div <= 9'h008;
         s_ff.wdt_slow <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign hrdata = s_ff.hrdata;
   assign hreadyout = s_ff.hreadyout;
   assign hresp = s_ff.hresp;
   assign active_src = s_ff.act;
   assign clock_hold = s_ff.hold;
   assign post_div = s_ff.post_div;
   assign lf_from_fast = s_ff.lf_fast;
   assign mult_active = s_ff.mult_act;
   assign tune_offset = s_ff.tune;
   assign tune_settling = s_ff.settling;
   assign idle_mode = s_ff.idle_q;
   assign sleep_mode = s_ff.sleep_q;
   assign wdt_from_slow_rc = s_ff.wdt_slow;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_mult_gate;
      s_ff.mult_act |-> s_ff.ifs[2:1] == 2'h3 && mult_avail;
   endproperty
   a_mult_gate: assert property (p_mult_gate)
      else $error("multiplier active outside 4/8 MHz internal config");

   property p_mult_read_zero;
      (addr_go && !hwrite && haddr[7:0] == oscs_pkg::OFS_TUNE &&
       !mult_avail) |=> !hrdata[oscs_pkg::TUNE_MULT_BIT];
   endproperty
   a_mult_read_zero: assert property (p_mult_read_zero)
      else $error("multiplier enable read nonzero when unavailable");

   property p_lf_fast;
      (s_ff.ifs == 3'h0 && s_ff.lfss) |-> post_div == 9'h100 && lf_from_fast;
   endproperty
   a_lf_fast: assert property (p_lf_fast)
      else $error("31.25 kHz path not divide by 256");

   property p_freq_follow;
      (s_ff.wr_ph && s_ff.addr_ph == oscs_pkg::OFS_CTRL &&
       hwdata[6:4] == 3'h7) |=> post_div == 9'h001 && !lf_from_fast;
   endproperty
   a_freq_follow: assert property (p_freq_follow)
      else $error("frequency select did not act next cycle");

   property p_hold_len;
      $rose(clock_hold) |-> clock_hold [*5];
   endproperty
   a_hold_len: assert property (p_hold_len)
      else $error("switch pause shorter than five cycles");

   property p_status_onehot;
      $onehot0({ostat_now, internal_stable_status_now, secrun_now});
   endproperty
   a_status_onehot: assert property (p_status_onehot)
      else $error("more than one source status bit set");

   property p_sec_gate;
      ($past(s_ff.sw) == oscs_pkg::SW_IDLE && s_ff.sw == oscs_pkg::SW_OLD &&
       s_ff.tgt == oscs_pkg::SRC_SEC) |-> $past(s_ff.sec_en);
   endproperty
   a_sec_gate: assert property (p_sec_gate)
      else $error("secondary switch started while oscillator disabled");

   property p_settle;
      (s_ff.wr_ph && s_ff.addr_ph == oscs_pkg::OFS_TUNE) |=> tune_settling;
   endproperty
   a_settle: assert property (p_settle)
      else $error("tuning write did not start settling");

   property p_idle_entry;
      (sleep_req && s_ff.pwr == oscs_pkg::PWR_RUN) |=>
         (idle_mode == $past(s_ff.idle_en)) && (sleep_mode != idle_mode);
   endproperty
   a_idle_entry: assert property (p_idle_entry)
      else $error("sleep request entered wrong power mode");

   property p_internal_stable_status_cause;
      internal_stable_status_now |-> s_ff.fast_rdy && active_src == oscs_pkg::SRC_INT;
   endproperty
   a_internal_stable_status_cause: assert property (p_internal_stable_status_cause)
      else $error("internal stable status without its cause");

   c_switch_done: cover property ($fell(clock_hold));
   c_idle_entry: cover property ($rose(idle_mode));
   c_mult_on: cover property ($rose(mult_active));

endmodule : oscs_top

`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the oscillator select and tuning block.
// Assumes the design's own assertions; AHB-Lite single word master here.
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, active_src;
   logic [2:0] hsize;
   logic [2:0] src_tick = 3'h0;
   logic [3:0] pcfg;
   logic two_spd, pri_rdy, fast_stb, sleep_req, wake_req;
   logic clock_hold, lf_from_fast, mult_active, tune_settling;
   logic idle_mode, sleep_mode, wdt_from_slow_rc;
   logic [8:0] post_div;
   logic [4:0] tune_offset;
   int failures, comparisons;
   int cycles = 0;
   int tc = 0;
   // Divide ratio per frequency code, low-frequency select clear
   localparam logic [8:0] DIV_TAB [8] = '{9'h000, 9'h040, 9'h020,
      9'h010, 9'h008, 9'h004, 9'h002, 9'h001};

   oscs_top #(.SETTLE_CYCLES(20)) oscs_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .primary_oscillator_config(pcfg),
      .two_speed_startup_config(two_spd), .primary_ready_pin(pri_rdy),
      .fast_stable_pin(fast_stb), .src_tick(src_tick),
      .sleep_req(sleep_req), .wake_req(wake_req),
      .active_src(active_src), .clock_hold(clock_hold),
      .post_div(post_div), .lf_from_fast(lf_from_fast),
      .mult_active(mult_active), .tune_offset(tune_offset),
      .tune_settling(tune_settling), .idle_mode(idle_mode),
      .sleep_mode(sleep_mode), .wdt_from_slow_rc(wdt_from_slow_rc));

   // ----------------------------------------------------------------
   // Clock, source ticks, timeout
   // ----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Coprime tick rates so old and new sources never share a pattern
   always @(posedge hclk) begin
      tc <= tc + 1;
      src_tick <= {(tc % 2) == 0, (tc % 5) == 0, (tc % 3) == 0};
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   task close_out();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task wait_rdy(output logic [31:0] q);
      logic r;
      do begin
         @(negedge hclk);
         r = hreadyout;
         q = hrdata;
         @(posedge hclk);
      end while (r !== 1'b1);
   endtask : wait_rdy

   task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                 output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_rdy(q);
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(q);
   endtask : ahb_xfer

   task ahb_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb_xfer(1'b1, a, d, q);
   endtask : ahb_wr

   task chk_rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb_xfer(1'b0, a, 32'h00000000, q);
      `CHK(q, e)
      `CHK(hresp, 1'b0)
   endtask : chk_rd

   task look(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask : look

   // Old source counted first, new source only after two old ticks
   task sw_wait(input logic [1:0] src, input int oi, input int ni);
      int n, oc, nc;
      n = 0;
      oc = 0;
      nc = 0;
      @(negedge hclk);
      while (clock_hold !== 1'b1 && n < 50) begin
         n++;
         @(negedge hclk);
      end
      `CHK(clock_hold, 1'b1)
      while (clock_hold === 1'b1 && n < 200) begin
         if (oc >= 2 && src_tick[ni] === 1'b1) nc++;
         if (src_tick[oi] === 1'b1) oc++;
         n++;
         @(negedge hclk);
      end
      `CHK(nc >= 3 && nc <= 4, 1'b1)
      `CHK(active_src, src)
   endtask : sw_wait

   task pulse(input logic slp);
      @(posedge hclk);
      if (slp) sleep_req <= 1'b1;
      else wake_req <= 1'b1;
      @(posedge hclk);
      sleep_req <= 1'b0;
      wake_req <= 1'b0;
      @(negedge hclk);
   endtask : pulse

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int n;
      logic [8:0] e;
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; pcfg = 4'h0;
      two_spd = 1'b0; pri_rdy = 1'b1; fast_stb = 1'b1;
      sleep_req = 1'b0; wake_req = 1'b0;
      failures = 0; comparisons = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      look(6);
      `CHK(active_src, oscs_pkg::SRC_PRI)
      `CHK(post_div, 9'h008)
      `CHK(wdt_from_slow_rc, 1'b1)
      chk_rd(oscs_pkg::OFS_CTRL, 32'h00000048);
      chk_rd(oscs_pkg::OFS_TUNE, 32'h00000000);
      chk_rd(8'h0C, 32'h00000000);
      // Multiplier bit absent without internal primary config
      ahb_wr(oscs_pkg::OFS_TUNE, 32'h0000005F);
      look(1);
      `CHK(tune_settling, 1'b1)
      `CHK(tune_offset, 5'h1F)
      look(25);
      `CHK(tune_settling, 1'b0)
      chk_rd(oscs_pkg::OFS_TUNE, 32'h0000001F);
      for (int i = 0; i < 8; i++) begin
         ahb_wr(oscs_pkg::OFS_CTRL, {25'h0, i[2:0], 4'h0});
         look(2);
         e = DIV_TAB[i];
         `CHK(post_div, e)
      end
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000000);
      ahb_wr(oscs_pkg::OFS_TUNE, 32'h00000080);
      look(2);
      `CHK(post_div, oscs_pkg::DIV_LF_FAST)
      `CHK(lf_from_fast, 1'b1)
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000010);
      look(2);
      `CHK(lf_from_fast, 1'b0)
      `CHK(post_div, 9'h040)
      @(posedge hclk);
      pcfg <= oscs_pkg::PCFG_INT_A;
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000070);
      ahb_wr(oscs_pkg::OFS_TUNE, 32'h00000040);
      look(2);
      `CHK(mult_active, 1'b1)
      chk_rd(oscs_pkg::OFS_TUNE, 32'h00000040);
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000050);
      look(2);
      `CHK(mult_active, 1'b0)
      // Source switches: primary to internal
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000072);
      sw_wait(oscs_pkg::SRC_INT, 0, 2);
      look(6);
      chk_rd(oscs_pkg::OFS_CTRL, 32'h00000076);
      fast_stb <= 1'b0;
      look(6);
      chk_rd(oscs_pkg::OFS_CTRL, 32'h00000072);
      fast_stb <= 1'b1;
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000062);
      look(2);
      `CHK(post_div, 9'h002)
      // Secondary refused until its oscillator is enabled
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000071);
      n = 0;
      repeat (20) begin
         @(negedge hclk);
         if (clock_hold === 1'b1) n++;
      end
      `CHK(n, 0)
      `CHK(active_src, oscs_pkg::SRC_INT)
      ahb_wr(oscs_pkg::OFS_SEC, 32'h00000008);
      sw_wait(oscs_pkg::SRC_SEC, 2, 1);
      look(6);
      chk_rd(oscs_pkg::OFS_SEC, 32'h00000048);
      chk_rd(oscs_pkg::OFS_CTRL, 32'h00000071);
      // Two-speed start-up waits for the primary ready pin
      two_spd <= 1'b1;
      pri_rdy <= 1'b0;
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000070);
      sw_wait(oscs_pkg::SRC_PRI, 1, 0);
      look(6);
      chk_rd(oscs_pkg::OFS_CTRL, 32'h00000070);
      pri_rdy <= 1'b1;
      look(6);
      chk_rd(oscs_pkg::OFS_CTRL, 32'h00000078);
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000074);
      chk_rd(oscs_pkg::OFS_CTRL, 32'h00000078);
      // Sleep instruction: idle, then full sleep
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h000000F0);
      pulse(1'b1);
      `CHK({idle_mode, sleep_mode}, 2'b10)
      pulse(1'b0);
      `CHK({idle_mode, sleep_mode}, 2'b00)
      ahb_wr(oscs_pkg::OFS_CTRL, 32'h00000070);
      pulse(1'b1);
      `CHK({idle_mode, sleep_mode}, 2'b01)
      pulse(1'b0);
      `CHK(wdt_from_slow_rc, 1'b1)
      close_out();
   end

endmodule : tb_top

`undef CHK

`default_nettype wire
